// [core/ahs_cfg.svh]
/*
 Constants of the axis homing sequencer: axis count, register word
 indices, field positions. Assumes a 32-bit AHB-Lite register bus.
*/
`ifndef AHS_CFG_SVH
`define AHS_CFG_SVH
`define AHS_NAX 5
`define AHS_IDX_CFG 6'h00
`define AHS_IDX_DIR 6'h01
`define AHS_IDX_FEED 6'h02
`define AHS_IDX_GEAR 6'h03
`define AHS_IDX_OPT 6'h04
`define AHS_IDX_CMD 6'h05
`define AHS_IDX_STAT 6'h06
`define AHS_IDX_FIN 6'h07
`define AHS_GRP_SCALAR 3'h0
`define AHS_GRP_RAPID 3'h1
`define AHS_GRP_LOW 3'h2
`define AHS_GRP_LNEG 3'h3
`define AHS_GRP_LPOS 3'h4
`define AHS_CFG_BLK_BIT 1
`define AHS_CFG_PROG_BIT 3
`define AHS_CFG_NO_MARKER_VARIANT_SEL_BIT 6
`define AHS_CFG_MARKER_PULSE_USE_SEL_BIT 7
`define AHS_OPT_ABS_BIT 0
`define AHS_OPT_LIM_BIT 6
`define AHS_OPT_GRAT_LSB 8
`define AHS_CMD_SEL_LSB 0
`define AHS_CMD_START_BIT 8
`define AHS_CMD_PROG_BIT 9
`define AHS_CMD_CAP_BIT 10
`define AHS_CMD_ABORT_BIT 11
`define AHS_ST_HOMED_LSB 0
`define AHS_ST_VALID_LSB 8
`define AHS_ST_BUSY_LSB 16
`define AHS_ST_TRIP_LSB 24
`endif

// [core/ahs_pin_sync.sv]
/*
 Three-stage pin synchroniser with agreement filter and edge pulses.
 Assumes the pin is asynchronous to hclk.
*/
`timescale 1ns/1ps
module ahs_pin_sync
	import ahs_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	ahs_sync_t q, d;

	always_comb
	begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.rise = 1'b0;
		d.fall = 1'b0;
		if (q.s2 == q.s3)
		begin
			d.lvl = q.s3;
			d.rise = q.s3 & ~q.lvl;
			d.fall = ~q.s3 & q.lvl;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q <= '0;
		else
			q <= d;
	end

	assign level = q.lvl;
	assign rise = q.rise;
	assign fall = q.fall;

	a_sync_rise: assert property (@(posedge hclk) disable iff (!hresetn)
		rise |-> level && !$past(level) && !fall)
		else $error("rise pulse without a new level");
	a_sync_once: assert property (@(posedge hclk) disable iff (!hresetn)
		rise |=> !rise)
		else $error("one edge gave two pulses");
endmodule

// [core/ahs_pkg.sv]
/*
 Types of the axis homing sequencer. Assumes ahs_cfg.svh on the
 include path.
*/
`include "ahs_cfg.svh"
package ahs_pkg;
	typedef enum logic [2:0] {AHS_IDLE, AHS_RAPID, AHS_LOW, AHS_FINAL,
		AHS_DONE} ahs_st_t;
	typedef logic signed [31:0] ahs_pos_t;
	typedef struct packed {
		logic en;
		logic rev;
		logic [15:0] speed;
	} ahs_drive_t;
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic rise;
		logic fall;
	} ahs_sync_t;
	typedef struct packed {
		ahs_st_t [`AHS_NAX-1:0] st;
		logic [`AHS_NAX-1:0] flip;
		ahs_drive_t [`AHS_NAX-1:0] drv;
		ahs_pos_t [`AHS_NAX-1:0] org;
		logic [`AHS_NAX-1:0] valid;
		logic [`AHS_NAX-1:0] homed;
		logic [`AHS_NAX-1:0] trip;
		logic [7:0] cfg;
		logic [`AHS_NAX-1:0] axis_home_dir_bit;
		logic [`AHS_NAX-1:0] feed_rev;
		logic [31:0] gear;
		logic abs_en;
		logic lim_en;
		logic [`AHS_NAX-1:0] grat;
		logic [15:0] final_search_speed;
		logic [`AHS_NAX-1:0][15:0] rapid;
		logic [`AHS_NAX-1:0][15:0] low;
		ahs_pos_t [`AHS_NAX-1:0] lneg;
		ahs_pos_t [`AHS_NAX-1:0] lpos;
		logic wr;
		logic [5:0] widx;
		logic [31:0] rdata;
	} ahs_state_t;
endpackage

// [core/ahs_top.sv]
/*
 Axis homing sequencer: AHB-Lite register slave, per-axis home return
 state machines, origin capture and soft travel limits.
 Assumes hclk at 200 MHz, position feedback on hclk, switch and
 marker pins asynchronous to hclk.
*/
`timescale 1ns/1ps
`include "ahs_cfg.svh"
module ahs_top
	import ahs_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [`AHS_NAX-1:0] axis_decel_switch_in,
	input wire logic [`AHS_NAX-1:0] marker_pulse_in,
	input wire ahs_pos_t [`AHS_NAX-1:0] axis_pos,
	output ahs_drive_t [`AHS_NAX-1:0] axis_drive,
	output logic [`AHS_NAX-1:0] axis_homed,
	output logic [`AHS_NAX-1:0] axis_limit_trip,
	output logic [`AHS_NAX-1:0] grating_fitted
);
	ahs_state_t s_q, s_d;
	logic [`AHS_NAX-1:0] dec_rise, dec_fall, mk_rise;
	logic [`AHS_NAX-1:0] sel, go, at_org, busy;
	logic cmd_wr, cap, abort, programmed_home_cmd, bus_ok;
	logic home_block_variant_sel, marker_pulse_use_sel;
	logic no_marker_variant_sel;
	logic [2:0] wgrp, rgrp;
	logic [2:0] wax, rax;
	logic [31:0] rd_val;
	ahs_pos_t rel;

	genvar g;
	generate
		for (g = 0; g < `AHS_NAX; g++)
		begin : g_pin
			ahs_pin_sync u_dec
			(
				.hclk(hclk),
				.hresetn(hresetn),
				.pin(axis_decel_switch_in[g]),
				.level(),
				.rise(dec_rise[g]),
				.fall(dec_fall[g])
			);
			ahs_pin_sync u_mk
			(
				.hclk(hclk),
				.hresetn(hresetn),
				.pin(marker_pulse_in[g]),
				.level(),
				.rise(mk_rise[g]),
				.fall()
			);
		end
	endgenerate

	// Shared mode bits for every axis
	assign home_block_variant_sel = s_q.cfg[`AHS_CFG_BLK_BIT];
	assign marker_pulse_use_sel = s_q.cfg[`AHS_CFG_MARKER_PULSE_USE_SEL_BIT];
	assign no_marker_variant_sel = s_q.cfg[`AHS_CFG_NO_MARKER_VARIANT_SEL_BIT];

	// Command word decode in the write data phase
	assign cmd_wr = s_q.wr && (s_q.widx == `AHS_IDX_CMD);
	assign sel = cmd_wr ? hwdata[`AHS_CMD_SEL_LSB +: `AHS_NAX] : '0;
	assign programmed_home_cmd = hwdata[`AHS_CMD_PROG_BIT]
		& ~s_q.cfg[`AHS_CFG_PROG_BIT];
	assign go = sel & {`AHS_NAX{hwdata[`AHS_CMD_START_BIT]
		| programmed_home_cmd}};
	assign cap = cmd_wr & hwdata[`AHS_CMD_CAP_BIT] & s_q.abs_en;
	assign abort = cmd_wr & hwdata[`AHS_CMD_ABORT_BIT];

	assign bus_ok = hsel & hready & htrans[1] & (haddr[31:8] == 24'h0);
	assign rgrp = haddr[7:5];
	assign rax = haddr[4:2];
	assign wgrp = s_q.widx[5:3];
	assign wax = s_q.widx[2:0];

	always_comb
	begin
		for (int i = 0; i < `AHS_NAX; i++)
		begin
			at_org[i] = (axis_pos[i] == s_q.org[i]);
			busy[i] = (s_q.st[i] != AHS_IDLE);
		end
	end

	// Register read mux, unmapped words read zero
	always_comb
	begin
		rd_val = 32'h0;
		if (rgrp == `AHS_GRP_SCALAR)
		begin
			case (haddr[7:2])
				`AHS_IDX_CFG: rd_val[7:0] = s_q.cfg;
				`AHS_IDX_DIR: rd_val[`AHS_NAX-1:0] = s_q.axis_home_dir_bit;
				`AHS_IDX_FEED: rd_val[`AHS_NAX-1:0] = s_q.feed_rev;
				`AHS_IDX_GEAR: rd_val = s_q.gear;
				`AHS_IDX_OPT:
				begin
					rd_val[`AHS_OPT_ABS_BIT] = s_q.abs_en;
					rd_val[`AHS_OPT_LIM_BIT] = s_q.lim_en;
					rd_val[`AHS_OPT_GRAT_LSB +: `AHS_NAX] = s_q.grat;
				end
				`AHS_IDX_STAT:
				begin
					rd_val[`AHS_ST_HOMED_LSB +: `AHS_NAX] = s_q.homed;
					rd_val[`AHS_ST_VALID_LSB +: `AHS_NAX] = s_q.valid;
					rd_val[`AHS_ST_BUSY_LSB +: `AHS_NAX] = busy;
					rd_val[`AHS_ST_TRIP_LSB +: `AHS_NAX] = s_q.trip;
				end
				`AHS_IDX_FIN: rd_val[15:0] = s_q.final_search_speed;
				default: rd_val = 32'h0;
			endcase
		end
		else if (rax < 3'(`AHS_NAX))
		begin
			case (rgrp)
				`AHS_GRP_RAPID: rd_val[15:0] = s_q.rapid[rax];
				`AHS_GRP_LOW: rd_val[15:0] = s_q.low[rax];
				`AHS_GRP_LNEG: rd_val = s_q.lneg[rax];
				`AHS_GRP_LPOS: rd_val = s_q.lpos[rax];
				default: rd_val = 32'h0;
			endcase
		end
	end

	always_comb
	begin
		s_d = s_q;
		rel = '0;
		// Address phase
		s_d.wr = bus_ok & hwrite;
		s_d.widx = haddr[7:2];
		if (bus_ok && !hwrite)
			s_d.rdata = rd_val;
		// Data phase writes
		if (s_q.wr && wgrp == `AHS_GRP_SCALAR)
		begin
			case (s_q.widx)
				`AHS_IDX_CFG: s_d.cfg = hwdata[7:0];
				`AHS_IDX_DIR:
				begin
					s_d.axis_home_dir_bit = hwdata[`AHS_NAX-1:0];
					s_d.valid = s_q.valid & ~(s_q.axis_home_dir_bit
						^ hwdata[`AHS_NAX-1:0]);
				end
				`AHS_IDX_FEED:
				begin
					s_d.feed_rev = hwdata[`AHS_NAX-1:0];
					s_d.valid = s_q.valid & ~(s_q.feed_rev
						^ hwdata[`AHS_NAX-1:0]);
				end
				`AHS_IDX_GEAR:
				begin
					s_d.gear = hwdata;
					if (hwdata != s_q.gear)
						s_d.valid = '0;
				end
				`AHS_IDX_OPT:
				begin
					s_d.abs_en = hwdata[`AHS_OPT_ABS_BIT];
					s_d.lim_en = hwdata[`AHS_OPT_LIM_BIT];
					s_d.grat = hwdata[`AHS_OPT_GRAT_LSB +: `AHS_NAX];
				end
				`AHS_IDX_FIN: s_d.final_search_speed = hwdata[15:0];
				default: s_d.cfg = s_q.cfg;
			endcase
		end
		else if (s_q.wr && wax < 3'(`AHS_NAX))
		begin
			case (wgrp)
				`AHS_GRP_RAPID: s_d.rapid[wax] = hwdata[15:0];
				`AHS_GRP_LOW: s_d.low[wax] = hwdata[15:0];
				`AHS_GRP_LNEG: s_d.lneg[wax] = hwdata;
				`AHS_GRP_LPOS: s_d.lpos[wax] = hwdata;
				default: s_d.gear = s_q.gear;
			endcase
		end
		// Per-axis home return sequence
		for (int i = 0; i < `AHS_NAX; i++)
		begin
			unique case (s_q.st[i])
				AHS_IDLE:
					if (go[i])
					begin
						s_d.st[i] = AHS_RAPID;
						s_d.valid[i] = 1'b0;
						s_d.flip[i] = 1'b0;
					end
					else if (cap && sel[i])
					begin
						s_d.org[i] = axis_pos[i];
						s_d.valid[i] = 1'b1;
					end
				AHS_RAPID:
					if (dec_rise[i])
					begin
						if (!marker_pulse_use_sel && no_marker_variant_sel)
							s_d.st[i] = AHS_DONE;
						else
						begin
							s_d.st[i] = AHS_LOW;
							s_d.flip[i] = home_block_variant_sel;
						end
					end
				AHS_LOW:
					if (dec_fall[i])
						s_d.st[i] = marker_pulse_use_sel ? AHS_FINAL
							: AHS_DONE;
				AHS_FINAL:
					if (mk_rise[i])
						s_d.st[i] = AHS_DONE;
				AHS_DONE:
				begin
					s_d.st[i] = AHS_IDLE;
					s_d.org[i] = axis_pos[i];
					s_d.valid[i] = 1'b1;
				end
			endcase
			if (abort)
				s_d.st[i] = AHS_IDLE;
			// Drive outputs follow the next state
			s_d.drv[i].rev = s_d.axis_home_dir_bit[i] ^ s_d.flip[i];
			s_d.drv[i].en = 1'b1;
			unique case (s_d.st[i])
				AHS_RAPID: s_d.drv[i].speed = s_d.rapid[i];
				AHS_LOW: s_d.drv[i].speed = s_d.low[i];
				AHS_FINAL: s_d.drv[i].speed = s_d.final_search_speed;
				AHS_IDLE, AHS_DONE:
				begin
					s_d.drv[i].en = 1'b0;
					s_d.drv[i].speed = 16'h0;
				end
			endcase
			s_d.homed[i] = s_q.valid[i] & at_org[i];
			rel = ahs_pos_t'(axis_pos[i] - s_q.org[i]);
			s_d.trip[i] = s_q.lim_en & s_q.valid[i]
				& ((rel < s_q.lneg[i]) | (rel > s_q.lpos[i]));
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	assign axis_drive = s_q.drv;
	assign axis_homed = s_q.homed;
	assign axis_limit_trip = s_q.trip;
	assign grating_fitted = s_q.grat;

	a_reset_no_origin: assert property (@(posedge hclk)
		disable iff (!hresetn) !$past(hresetn) |-> s_q.valid == '0)
		else $error("origin valid right after reset");
	a_rapid_speed: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[0] == AHS_RAPID
		|-> s_q.drv[0].en && s_q.drv[0].speed == s_q.rapid[0])
		else $error("rapid approach speed wrong");
	a_block_speed: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[0] == AHS_LOW
		|-> s_q.drv[0].en && s_q.drv[0].speed == s_q.low[0])
		else $error("switch block speed wrong");
	a_final_speed: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[0] == AHS_FINAL
		|-> s_q.drv[0].speed == s_q.final_search_speed)
		else $error("final search speed wrong");
	a_marker_halt: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[0] == AHS_FINAL && mk_rise[0]
		|=> !s_q.drv[0].en ##1 s_q.valid[0])
		else $error("axis did not halt on marker");
	a_homed_at_org: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.homed[0]
		|-> $past(at_org[0]) && $past(s_q.valid[0]))
		else $error("homed while away from origin");
	a_rapid_dir: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[0] == AHS_RAPID
		|-> s_q.drv[0].rev == s_q.axis_home_dir_bit[0])
		else $error("home direction wrong");
	a_dir_loss: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.wr && s_q.widx == `AHS_IDX_DIR
		&& hwdata[0] != s_q.axis_home_dir_bit[0]
		&& s_q.st[0] != AHS_DONE |=> !s_q.valid[0])
		else $error("origin kept after direction change");
	a_limit_off: assert property (@(posedge hclk)
		disable iff (!hresetn) !$past(s_q.lim_en) |-> !s_q.trip[0])
		else $error("limit trip while limits disabled");
	a_start_clears: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[0] == AHS_IDLE && go[0]
		|=> !s_q.valid[0])
		else $error("origin kept at home start");
	a_block_flip: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[3] == AHS_RAPID && dec_rise[3]
		&& !abort && marker_pulse_use_sel
		|=> s_q.drv[3].rev == (s_q.axis_home_dir_bit[3]
		^ $past(home_block_variant_sel)))
		else $error("direction after switch wrong");
	a_marker_mode: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[0] == AHS_LOW && dec_fall[0]
		&& !abort |=> s_q.st[0] == ($past(marker_pulse_use_sel)
		? AHS_FINAL : AHS_DONE))
		else $error("wrong step after switch release");
	a_variant_b_stop: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[1] == AHS_RAPID && dec_rise[1]
		&& !abort && !marker_pulse_use_sel && no_marker_variant_sel
		|=> s_q.st[1] == AHS_DONE)
		else $error("variant B did not stop at switch");
	a_idle_stopped: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[0] == AHS_IDLE
		|-> !s_q.drv[0].en)
		else $error("idle axis still driven");
	a_done_origin: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[0] == AHS_DONE && !abort
		|=> s_q.valid[0] && s_q.org[0] == $past(axis_pos[0]))
		else $error("origin not latched on completion");
	a_cap_origin: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.st[4] == AHS_IDLE && cap && sel[4]
		&& !go[4]
		|=> s_q.valid[4] && s_q.org[4] == $past(axis_pos[4]))
		else $error("zero capture did not latch origin");
	a_prog_blocked: assert property (@(posedge hclk)
		disable iff (!hresetn) cmd_wr && hwdata[`AHS_CMD_PROG_BIT]
		&& !hwdata[`AHS_CMD_START_BIT]
		&& s_q.cfg[`AHS_CFG_PROG_BIT] && s_q.st[0] == AHS_IDLE
		|=> s_q.st[0] == AHS_IDLE)
		else $error("program command ran while disabled");
	a_grating_out: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.wr && s_q.widx == `AHS_IDX_OPT
		|=> grating_fitted
		== $past(hwdata[`AHS_OPT_GRAT_LSB +: `AHS_NAX]))
		else $error("grating setting not kept");
	a_limit_trip: assert property (@(posedge hclk)
		disable iff (!hresetn) s_q.lim_en && s_q.valid[4]
		&& ($signed(axis_pos[4] - s_q.org[4]) > s_q.lpos[4])
		|=> s_q.trip[4])
		else $error("limit exceeded without trip");
endmodule

// [sim/ahs_axis_model.sv]
/*
 Far-side model: five servo axes, their deceleration switches and
 once-per-turn markers. Assumes the drive outputs of ahs_top on hclk.
*/
`timescale 1ns/1ps
`include "ahs_cfg.svh"
module ahs_axis_model
	import ahs_pkg::*;
#(
	parameter int SW_ON = 20,
	parameter int SW_LEN = 20
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire ahs_drive_t [`AHS_NAX-1:0] axis_drive,
	output ahs_pos_t [`AHS_NAX-1:0] axis_pos,
	output logic [`AHS_NAX-1:0] axis_decel_switch_in,
	output logic [`AHS_NAX-1:0] marker_pulse_in
);
	int dist_q [`AHS_NAX];
	logic [`AHS_NAX-1:0] en_q;
	int e;
	// Travel since the last start; position holds when stopped
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			en_q <= '0;
			axis_pos <= '0;
			for (int i = 0; i < `AHS_NAX; i++)
				dist_q[i] <= 0;
		end
		else
		begin
			en_q <= {axis_drive[4].en, axis_drive[3].en, axis_drive[2].en,
				axis_drive[1].en, axis_drive[0].en};
			for (int i = 0; i < `AHS_NAX; i++)
			begin
				if (axis_drive[i].en && !en_q[i])
					dist_q[i] <= 0;
				else if (axis_drive[i].en)
				begin
					dist_q[i] <= dist_q[i] + 1;
					if (axis_drive[i].rev)
						axis_pos[i] <= axis_pos[i] - 1;
					else
						axis_pos[i] <= axis_pos[i] + 1;
				end
			end
		end
	end
	// Higher-numbered axes meet their switch later; markers stay high 4 cycles
	always_comb
	begin
		e = 0;
		for (int i = 0; i < `AHS_NAX; i++)
		begin
			e = dist_q[i] - (SW_ON + 6 * i + SW_LEN);
			axis_decel_switch_in[i] = dist_q[i] >= SW_ON + 6 * i && e < 0;
			marker_pulse_in[i] = e >= 0 && e % 16 >= 8 && e % 16 < 12;
		end
	end
endmodule

// [sim/test_axis_homing_sequencer.sv]
/*
 Self-checking bench of the axis homing sequencer over AHB-Lite.
 Assumes ahs_top and ahs_axis_model; clock 200 MHz.
*/
`timescale 1ns/1ps
`include "ahs_cfg.svh"
module test_axis_homing_sequencer
	import ahs_pkg::*;
;
	localparam logic [31:0] A_CFG = 32'h00;
	localparam logic [31:0] A_DIR = 32'h04;
	localparam logic [31:0] A_GEAR = 32'h0c;
	localparam logic [31:0] A_OPT = 32'h10;
	localparam logic [31:0] A_CMD = 32'h14;
	localparam logic [31:0] A_ST = 32'h18;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [`AHS_NAX-1:0] sw, mk, homed, trip, grat;
	ahs_pos_t [`AHS_NAX-1:0] pos;
	ahs_drive_t [`AHS_NAX-1:0] drv;
	int err_count = 0;
	int total_checks = 0;
	always #2.5 hclk = ~hclk;
	ahs_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .axis_decel_switch_in(sw),
		.marker_pulse_in(mk), .axis_pos(pos), .axis_drive(drv),
		.axis_homed(homed), .axis_limit_trip(trip), .grating_fitted(grat));
	ahs_axis_model model (.hclk(hclk), .hresetn(hresetn), .axis_drive(drv),
		.axis_pos(pos), .axis_decel_switch_in(sw), .marker_pulse_in(mk));
	task wrap_up();
		$display("errors %0d checks %0d", err_count, total_checks);
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rdv);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rdv = hrdata;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, exp);
		chk(32'(hresp), 32'h0);
	endtask
	// Wait for a drive speed, then check its direction
	task wait_drv(input int i, input logic [15:0] spd, input logic rv);
		int n;
		n = 0;
		while (!(drv[i].en === 1'b1 && drv[i].speed === spd) && n < 300)
		begin
			@(posedge hclk);
			n++;
		end
		chk(32'(drv[i].rev), 32'(rv));
		chk(32'(n < 300), 32'h1);
	endtask
	// Kind 0: stopped, 1: marker high, 2: homed
	task wait_sig(input int i, input int k, input int lim);
		int n;
		n = 0;
		while (!(k == 0 && drv[i].en === 1'b0 || k == 1 && mk[i] === 1'b1
			|| k == 2 && homed[i] === 1'b1) && n < lim)
		begin
			@(posedge hclk);
			n++;
		end
		chk(32'(n < lim), 32'h1);
	endtask
	task home(input logic [31:0] cmd, input int i);
		wr(A_CMD, cmd);
		repeat (2) @(posedge hclk);
		wait_sig(i, 0, 400);
	endtask
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = '0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd(A_ST, 32'h0);
		chk(32'(homed), 32'h0);
		rd(32'ha0, 32'h0);
		wr(32'h1c, 32'h5);
		for (int i = 0; i < 5; i++)
		begin
			wr(32'h20 + 4 * i, 32'h100 + i);
			wr(32'h40 + 4 * i, 32'h20 + i);
		end
		rd(32'h44, 32'h21);
		wr(A_DIR, 32'h05);
		wr(A_CFG, 32'h80);
		wr(A_CMD, 32'h11f);
		wait_drv(0, 16'h100, 1'b1);
		wait_drv(0, 16'h20, 1'b1);
		wait_drv(0, 16'h5, 1'b1);
		wait_sig(0, 1, 200);
		wait_sig(0, 0, 8);
		wait_drv(1, 16'h5, 1'b0);
		wait_drv(2, 16'h5, 1'b1);
		for (int i = 0; i < 5; i++)
		begin
			wait_sig(i, 0, 400);
			wait_sig(i, 2, 10);
		end
		rd(A_ST, 32'h1f1f);
		wr(A_DIR, 32'h04);
		repeat (3) @(posedge hclk);
		rd(A_ST, 32'h1e1e);
		wr(A_GEAR, 32'h7);
		repeat (2) @(posedge hclk);
		rd(A_ST, 32'h0);
		wr(A_CFG, 32'h40);
		home(32'h102, 1);
		chk(32'(sw[1]), 32'h1);
		wait_sig(1, 2, 10);
		wr(A_CFG, 32'h0);
		home(32'h102, 1);
		chk(32'(sw[1]), 32'h0);
		wr(A_CFG, 32'h82);
		wr(A_DIR, 32'h0);
		wr(A_CMD, 32'h108);
		wait_drv(3, 16'h103, 1'b0);
		wait_drv(3, 16'h23, 1'b1);
		wait_sig(3, 0, 400);
		wr(A_CFG, 32'h08);
		wr(A_CMD, 32'h201);
		repeat (4) @(posedge hclk);
		chk(32'(drv[0].en), 32'h0);
		wr(A_CFG, 32'h0);
		home(32'h201, 0);
		wait_sig(0, 2, 10);
		wr(A_OPT, 32'h0);
		wr(A_CMD, 32'h410);
		repeat (4) @(posedge hclk);
		chk(32'(homed[4]), 32'h0);
		wr(A_OPT, 32'h1);
		wr(A_CMD, 32'h410);
		wait_sig(4, 2, 10);
		wr(32'h70, 32'hfffffff6);
		wr(32'h90, 32'hfffffffb);
		repeat (3) @(posedge hclk);
		chk(32'(trip[4]), 32'h0);
		wr(A_OPT, 32'h1641);
		repeat (3) @(posedge hclk);
		chk(32'(trip[4]), 32'h1);
		chk(32'(grat), 32'h16);
		rd(A_OPT, 32'h1641);
		wr(A_CMD, 32'h104);
		wait_drv(2, 16'h102, 1'b0);
		wr(A_CMD, 32'h804);
		repeat (2) @(posedge hclk);
		chk(32'(drv[2].en), 32'h0);
		rd(A_ST, 32'h10001b1b);
		wr(32'h08, 32'h01);
		repeat (2) @(posedge hclk);
		rd(A_ST, 32'h10001a1a);
		wrap_up();
	end
	initial
	begin
		repeat (20000) @(posedge hclk);
		err_count++;
		$display("[ERR] %0t run did not finish in time", $time);
		wrap_up();
	end
endmodule
